// *** bench/dmae_engine_monitor.sv ***
// port-level checker of the dma engine
`timescale 1ns/1ps
module dmae_engine_monitor
  import dmae_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NUM_CH-1:0] dreq,
  input wire logic [NUM_CH-1:0] dack,
  input wire logic              mReq,
  input wire logic [31:0]       mAddr,
  input wire logic              mWrite,
  input wire logic [1:0]        mSize,
  input wire logic [31:0]       mWdata,
  input wire logic              mAck,
  input wire logic [31:0]       mRdata,
  input wire logic              mErr,
  input wire logic [NUM_CH-1:0] chIrq,
  input wire logic              irq
);
  logic wrOk;
  assign wrOk = mReq && mWrite && mAck && !mErr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rdAck;
    mReq && !mWrite && mAck && !mErr;
  endsequence
  sequence busFault;
    mReq && mAck && mErr;
  endsequence
  ready_always_a: assert property (pready)
    else $error("apb ready low");
  unmapped_read_a: assert property (psel && penable && !pwrite && paddr >= 12'h1C0 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  req_hold_a: assert property (mReq && !mAck |=> mReq && $stable(mAddr) && $stable(mWrite) && $stable(mSize))
    else $error("master request changed before ack");
  read_write_a: assert property (rdAck |=> mReq && mWrite)
    else $error("read not followed by write");
  item_end_a: assert property (wrOk |=> !mReq && $onehot(dack))
    else $error("item end wrong");
  dack_pulse_a: assert property (dack != '0 |=> dack == '0)
    else $error("dack longer than one cycle");
  dack_cause_a: assert property (dack != '0 |-> $past(wrOk))
    else $error("dack without write ack");
  fault_stop_a: assert property (busFault |=> !mReq && dack == '0)
    else $error("bus error did not stop");
  irq_or_a: assert property (irq == |chIrq)
    else $error("irq not or of channels");
  byte_rep_a: assert property (mReq && mWrite && mSize == SIZE_BYTE |-> mWdata == {4{mWdata[7:0]}})
    else $error("byte not replicated");
endmodule

// *** bench/dmae_mem_model.sv ***
// memory side model: answers each master access after a chosen delay
`timescale 1ns/1ps
module dmae_mem_model
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic        mReq,
  input  wire logic [31:0] mAddr,
  output logic             mAck,
  output logic [31:0]      mRdata,
  output logic             mErr
);
  logic [1:0] waitQ;
  // any address answers, memory and peripherals alike
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      mAck  <= 1'b0;
      waitQ <= 2'h0;
    end
    else
    begin
      mAck  <= mReq && !mAck && waitQ == (slow ? 2'h3 : 2'h0);
      waitQ <= (!mReq || mAck) ? 2'h0 : (waitQ == 2'h3 ? waitQ : waitQ + 2'h1);
    end
  // released bus shows the inverse, so a late sample cannot pass
  assign mRdata = mAck ? 32'h44332211 : 32'hBBCCDDEE;
  // top nibble F is a faulty region
  assign mErr = mAck && mAddr[31:28] == 4'hF;
endmodule

// *** bench/tb.sv ***
// self-checking bench of the dma engine
`timescale 1ns/1ps
module tb
  import dmae_pkg::*;
;
  typedef struct {int ch; logic [11:0] cfg; logic [16:0] cnt; logic [31:0] src; logic [31:0] wd; logic [31:0] wa;} dmaeRow_t;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, mAddr, mWdata, mRdata, rq, lastWd, lastWa;
  logic [13:0] dreq = '0, dreqOn = '0, dack, chIrq, d;
  logic        pready, pslverr, mReq, mWrite, mAck, mErr, irq, re;
  logic [1:0]  mSize;
  int          fails = 0, testsRun = 0, cyc = 0;
  // each source address is aligned to its row's source size; last write address ends the row
  dmaeRow_t    rows [4] = '{'{0, 12'h829, 17'h1, 32'h1001, 32'h22, 32'h4000},
                            '{7, 12'h529, 17'h2, 32'h2002, 32'h44334433, 32'h4002},
                            '{13, 12'h229, 17'h3, 32'h3000, 32'h11111111, 32'h4002},
                            '{3, 12'h029, 17'h4, 32'h1003, 32'h44444444, 32'h4003}};
  dmae_engine dut_u (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dreq(dreq), .dack(dack), .mReq(mReq),
    .mAddr(mAddr), .mWrite(mWrite), .mSize(mSize), .mWdata(mWdata), .mAck(mAck), .mRdata(mRdata), .mErr(mErr),
    .chIrq(chIrq), .irq(irq));
  dmae_mem_model mem_u (.clk(clk), .nrst(nrst), .slow(slow), .mReq(mReq), .mAddr(mAddr), .mAck(mAck),
    .mRdata(mRdata), .mErr(mErr));
  always #5 clk = ~clk;
  // peripheral drops its request once served, else another item follows
  always @(posedge clk) dreq <= (dreq | dreqOn) & ~dack;
  always @(posedge clk)
  begin
    if (mReq && mWrite && mAck)
    begin
      lastWd <= mWdata;
      lastWa <= mAddr;
    end
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      completeRun();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  function automatic logic [11:0] ra(input int c, input logic [4:0] o);
    return 12'(c * 32) | {7'h0, o};
  endfunction
  task automatic waitFlag(input int c, input int b);
    rq = '0;
    while (rq[b] !== 1'b1) apb(1'b0, ra(c, OFF_FLAG), '0);
  endtask
  task automatic waitDack();
    do @(posedge clk); while (dack === '0);
    d = dack;
  endtask
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, ra(0, OFF_CFG), '0);
    chk(rq, '0);
    apb(1'b0, 12'h1C0, '0);
    chk({rq[31:1], re}, 32'h1);
    foreach (rows[i])
    begin
      apb(1'b1, ra(rows[i].ch, OFF_CNT), 32'(rows[i].cnt));
      apb(1'b1, ra(rows[i].ch, OFF_SRC), rows[i].src);
      apb(1'b1, ra(rows[i].ch, OFF_DST), 32'h4000);
      apb(1'b1, ra(rows[i].ch, OFF_CFG), 32'(rows[i].cfg));
      waitFlag(rows[i].ch, FLAG_DONE);
      chk(lastWd, rows[i].wd);
      chk(lastWa, rows[i].wa);
      apb(1'b0, ra(rows[i].ch, OFF_REM), '0);
      chk(rq, '0);
      apb(1'b0, ra(rows[i].ch, OFF_FLAG), '0);
      chk(rq, 32'h3);
      apb(1'b0, ra(rows[i].ch, OFF_CFG), '0);
      chk(rq, 32'(rows[i].cfg & 12'hFFE));
      chk(32'(irq), '0);
      apb(1'b1, ra(rows[i].ch, OFF_MASK), 32'h7);
      chk(32'(chIrq[rows[i].ch]), 32'h1);
      apb(1'b1, ra(rows[i].ch, OFF_FLAG), 32'h7);
      chk(32'(irq), '0);
    end
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, ra(1, OFF_CNT), 32'h1);
      apb(1'b1, ra(2, OFF_CNT), 32'h1);
      apb(1'b1, ra(1, OFF_CFG), 32'h0A01);
      apb(1'b1, ra(2, OFF_CFG), k ? 32'h0AC1 : 32'h0A01);
      dreqOn <= 14'h0006;
      @(posedge clk);
      dreqOn <= '0;
      waitDack();
      chk(32'(d), k ? 32'h4 : 32'h2);
      waitDack();
      chk(32'(d), k ? 32'h2 : 32'h4);
    end
    apb(1'b1, ra(4, OFF_CNT), 32'h1);
    apb(1'b1, ra(4, OFF_CFG), 32'h0A05);
    apb(1'b1, ra(4, OFF_SWTRIG), 32'h1);
    waitDack();
    chk(32'(d), 32'h10);
    apb(1'b1, ra(5, OFF_CNT), 32'h2);
    apb(1'b1, ra(5, OFF_SRC), 32'hF0000000);
    apb(1'b1, ra(5, OFF_CFG), 32'h0A09);
    waitFlag(5, FLAG_ERR);
    chk(rq, 32'h4);
    apb(1'b0, ra(5, OFF_CFG), '0);
    chk(rq, 32'h0A08);
    apb(1'b0, ra(5, OFF_REM), '0);
    chk(rq, 32'h2);
    slow <= 1'b1;
    apb(1'b1, ra(6, OFF_CNT), 32'h2);
    apb(1'b1, ra(6, OFF_CFG), 32'h0A0B);
    waitFlag(6, FLAG_DONE);
    apb(1'b0, ra(6, OFF_CFG), '0);
    chk(rq, 32'h0A0B);
    apb(1'b1, ra(6, OFF_CFG), '0);
    slow <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b1, ra(0, OFF_CNT), 32'h0001FFFF);
    apb(1'b0, ra(0, OFF_CNT), '0);
    chk(rq, 32'h10000);
    // ----------------------------------------------------------------
    // mid-run reset: a running circular channel must stop and lose its setup
    // ----------------------------------------------------------------
    apb(1'b1, ra(6, OFF_CNT), 32'h2);
    apb(1'b1, ra(6, OFF_CFG), 32'h0A0B);
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    chk(32'({mReq, irq, dack}), '0);
    chk(prdata, '0);
    nrst <= 1'b1;
    apb(1'b0, ra(6, OFF_CFG), '0);
    chk(rq, '0);
    apb(1'b0, ra(6, OFF_REM), '0);
    chk(rq, '0);
    chk(32'(mReq), '0);
    completeRun();
  end
endmodule
bind dmae_engine dmae_engine_monitor mon_u (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dreq(dreq), .dack(dack),
  .mReq(mReq), .mAddr(mAddr), .mWrite(mWrite), .mSize(mSize), .mWdata(mWdata), .mAck(mAck), .mRdata(mRdata),
  .mErr(mErr), .chIrq(chIrq), .irq(irq));

// *** rtl/dmae_arbiter.sv ***
// per-controller arbiter: software priority, lowest index on a tie
`timescale 1ns/1ps
module dmae_arbiter
  import dmae_pkg::*;
#(
  parameter int CH = CH_PER_CTRL
)
(
  input  wire logic                  pend,
  input  wire logic [CH-1:0]         reqVec,
  input  wire logic [CH-1:0][1:0]    prioVec,
  output logic                       valid,
  output logic [$clog2(CH)-1:0]      idx
);

  logic [1:0] best;

  // ----------------------------------------------------------------
  // scan upward; only a strictly higher level displaces the holder
  // ----------------------------------------------------------------
  always_comb
  begin
    valid = 1'b0;
    idx   = '0;
    best  = PRIO_LOW;
    for (int i = 0; i < CH; i++)
    begin
      if (pend && reqVec[i] && (!valid || prioVec[i] > best))
      begin
        valid = 1'b1;
        idx   = ($clog2(CH))'(i);
        best  = prioVec[i];
      end
    end
  end

endmodule

// *** rtl/dmae_engine.sv ***
// two-controller fourteen-channel dma engine with apb registers
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps

module dmae_engine
  import dmae_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [APB_AW-1:0]   paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_CH-1:0]   dreq,
  output logic [NUM_CH-1:0]        dack,
  output logic                     mReq,
  output logic [31:0]              mAddr,
  output logic                     mWrite,
  output logic [1:0]               mSize,
  output logic [31:0]              mWdata,
  input  wire logic                mAck,
  input  wire logic [31:0]         mRdata,
  input  wire logic                mErr,
  output logic [NUM_CH-1:0]        chIrq,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dmaeChan_t [NUM_CH-1:0] chan;
    dmaeState_t             st;
    logic [3:0]             curCh;
    logic                   turn;
    logic [NUM_CH-1:0]      dreqS1;
    logic [NUM_CH-1:0]      dreqS2;
    logic [NUM_CH-1:0]      ack;
    logic [31:0]            prdata;
    logic                   mReq;
    logic [31:0]            mAddr;
    logic                   mWrite;
    logic [1:0]             mSize;
    logic [31:0]            mWdata;
  } dmaeTop_t;

  dmaeTop_t s_q;
  dmaeTop_t s_d;

  // ----------------------------------------------------------------
  // request qualification and arbitration
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0]                        chPend;
  logic [NUM_CTRL-1:0][CH_PER_CTRL-1:0]     arbReq;
  logic [NUM_CTRL-1:0][CH_PER_CTRL-1:0][1:0] arbPrio;
  logic [NUM_CTRL-1:0]                      arbValid;
  logic [NUM_CTRL-1:0][2:0]                 arbIdx;

  genvar g;
  genvar k;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : gChan
      dmaeChan_t ch;
      assign ch = s_q.chan[g];
      // m2m needs no request; otherwise the selected source of demand
      assign chPend[g] = ch.cfg.en && (ch.rem != '0) &&
                         (ch.cfg.m2m || (ch.cfg.swSel ? ch.swPend : s_q.dreqS2[g]));
      assign chIrq[g]  = |(ch.flags & ch.mask);
    end
    for (g = 0; g < NUM_CTRL; g++)
    begin : gCtrl
      for (k = 0; k < CH_PER_CTRL; k++)
      begin : gMap
        assign arbReq[g][k]  = chPend[g*CH_PER_CTRL+k];
        assign arbPrio[g][k] = s_q.chan[g*CH_PER_CTRL+k].cfg.prio;
      end
      // one arbiter per controller
      dmae_arbiter #(
        .CH      (CH_PER_CTRL)
      ) uArb (
        .pend    (s_q.st == ST_IDLE),
        .reqVec  (arbReq[g]),
        .prioVec (arbPrio[g]),
        .valid   (arbValid[g]),
        .idx     (arbIdx[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [3:0] aCh;
  logic [4:0] aOff;
  logic       aHit;

  assign aCh  = paddr[8:5];
  assign aOff = paddr[4:0];
  assign aHit = (paddr[APB_AW-1:9] == '0) && (aCh < 4'(NUM_CH)) && (paddr[1:0] == 2'h0);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic             selHi;
  logic [3:0]       win;
  logic [3:0]       cc;
  logic [31:0]      shifted;
  logic [31:0]      item;
  logic [CNT_W-1:0] newRem;
  dmaeCfg_t         cfgNew;

  always_comb
  begin
    s_d     = s_q;
    s_d.dreqS1 = dreq;
    s_d.dreqS2 = s_q.dreqS1;
    s_d.ack    = '0;
    cfgNew  = dmaeCfg_t'(pwdata[$bits(dmaeCfg_t)-1:0]);
    cc      = s_q.curCh;
    shifted = mRdata >> {s_q.chan[cc].curSrc[1:0], 3'h0};
    item    = shifted;
    newRem  = s_q.chan[cc].rem - 17'h00001;
    selHi   = arbValid[1] && (s_q.turn || !arbValid[0]);
    win     = selHi ? 4'(CH_PER_CTRL) + {1'b0, arbIdx[1]} : {1'b0, arbIdx[0]};

    // source item zero-extended; destination takes its low lanes
    case (s_q.chan[cc].cfg.srcSize)
      SIZE_BYTE: item = {24'h000000, shifted[7:0]};
      SIZE_HALF: item = {16'h0000, shifted[15:0]};
      default:   item = shifted;
    endcase

    // read data prepared in setup so it comes from a flop in access
    if (psel && !penable)
    begin
      s_d.prdata = 32'h00000000;
      if (aHit)
      begin
        case (aOff)
          OFF_CFG:  s_d.prdata = 32'(s_q.chan[aCh].cfg);
          OFF_CNT:  s_d.prdata = 32'(s_q.chan[aCh].cnt);
          OFF_SRC:  s_d.prdata = s_q.chan[aCh].src;
          OFF_DST:  s_d.prdata = s_q.chan[aCh].dst;
          OFF_REM:  s_d.prdata = 32'(s_q.chan[aCh].rem);
          OFF_FLAG: s_d.prdata = 32'(s_q.chan[aCh].flags);
          OFF_MASK: s_d.prdata = 32'(s_q.chan[aCh].mask);
          default:  s_d.prdata = 32'(s_q.chan[aCh].swPend);
        endcase
      end
    end

    // register writes come first so a hardware flag set below wins
    if (psel && penable && pwrite && aHit)
    begin
      case (aOff)
        OFF_CFG:
        begin
          s_d.chan[aCh].cfg = cfgNew;
          if (cfgNew.en && !s_q.chan[aCh].cfg.en)
          begin
            s_d.chan[aCh].rem    = s_q.chan[aCh].cnt;
            s_d.chan[aCh].curSrc = s_q.chan[aCh].src;
            s_d.chan[aCh].curDst = s_q.chan[aCh].dst;
          end
        end
        OFF_CNT:
        begin
          // 65536 is the ceiling; bit 16 set gives 65536, bits above 16 are ignored
          s_d.chan[aCh].cnt = pwdata[16] ? MAX_COUNT : {1'b0, pwdata[15:0]};
        end
        OFF_SRC:  s_d.chan[aCh].src = pwdata;
        OFF_DST:  s_d.chan[aCh].dst = pwdata;
        OFF_FLAG: s_d.chan[aCh].flags = s_q.chan[aCh].flags & ~pwdata[2:0];
        OFF_MASK: s_d.chan[aCh].mask = pwdata[2:0];
        OFF_SWTRIG:
        begin
          if (pwdata[0])
          begin
            s_d.chan[aCh].swPend = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // transfer engine: one read then one write per item
    // ----------------------------------------------------------------
    case (s_q.st)
      ST_IDLE:
      begin
        if (arbValid[0] || arbValid[1])
        begin
          // the two controllers alternate on the single master port
          s_d.turn   = !selHi;
          s_d.curCh  = win;
          s_d.mReq   = 1'b1;
          s_d.mAddr  = s_q.chan[win].curSrc;
          s_d.mWrite = 1'b0;
          s_d.mSize  = s_q.chan[win].cfg.srcSize;
          s_d.st     = ST_READ;
        end
      end
      ST_READ:
      begin
        if (mAck)
        begin
          if (mErr)
          begin
            s_d.chan[cc].flags[FLAG_ERR] = 1'b1;
            s_d.chan[cc].cfg.en          = 1'b0;
            s_d.mReq = 1'b0;
            s_d.st   = ST_IDLE;
          end
          else
          begin
            s_d.mAddr  = s_q.chan[cc].curDst;
            s_d.mWrite = 1'b1;
            s_d.mSize  = s_q.chan[cc].cfg.dstSize;
            case (s_q.chan[cc].cfg.dstSize)
              SIZE_BYTE: s_d.mWdata = {4{item[7:0]}};
              SIZE_HALF: s_d.mWdata = {2{item[15:0]}};
              default:   s_d.mWdata = item;
            endcase
            s_d.st = ST_WRITE;
          end
        end
      end
      ST_WRITE:
      begin
        if (mAck)
        begin
          s_d.mReq   = 1'b0;
          s_d.mWrite = 1'b0;
          s_d.st     = ST_IDLE;
          if (mErr)
          begin
            s_d.chan[cc].flags[FLAG_ERR] = 1'b1;
            s_d.chan[cc].cfg.en          = 1'b0;
          end
          else
          begin
            s_d.ack[cc]           = 1'b1;
            s_d.chan[cc].swPend   = 1'b0;
            s_d.chan[cc].rem      = newRem;
            if (s_q.chan[cc].cfg.srcInc)
            begin
              s_d.chan[cc].curSrc = s_q.chan[cc].curSrc + (32'h00000001 << s_q.chan[cc].cfg.srcSize);
            end
            if (s_q.chan[cc].cfg.dstInc)
            begin
              s_d.chan[cc].curDst = s_q.chan[cc].curDst + (32'h00000001 << s_q.chan[cc].cfg.dstSize);
            end
            if (newRem == (s_q.chan[cc].cnt >> 1))
            begin
              s_d.chan[cc].flags[FLAG_HALF] = 1'b1;
            end
            if (newRem == '0)
            begin
              s_d.chan[cc].flags[FLAG_DONE] = 1'b1;
              if (s_q.chan[cc].cfg.circ)
              begin
                // wrap to the programmed buffer and keep serving
                s_d.chan[cc].rem    = s_q.chan[cc].cnt;
                s_d.chan[cc].curSrc = s_q.chan[cc].src;
                s_d.chan[cc].curDst = s_q.chan[cc].dst;
              end
              else
              begin
                s_d.chan[cc].cfg.en = 1'b0;
              end
            end
          end
        end
      end
      default:
      begin
        s_d.st   = ST_IDLE;
        s_d.mReq = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !aHit;
  assign prdata  = s_q.prdata;
  assign dack    = s_q.ack;
  assign mReq    = s_q.mReq;
  assign mAddr   = s_q.mAddr;
  assign mWrite  = s_q.mWrite;
  assign mSize   = s_q.mSize;
  assign mWdata  = s_q.mWdata;
  assign irq     = |chIrq;

endmodule

// *** shared/dmae_pkg.sv ***
// shared constants and types of the two-controller dma engine
package dmae_pkg;

  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int NUM_CTRL    = 2;
  localparam int CH_PER_CTRL = 7;
  localparam int NUM_CH      = NUM_CTRL * CH_PER_CTRL;
  localparam int CNT_W       = 17;
  localparam int APB_AW      = 12;

  // ----------------------------------------------------------------
  // register map: one 32-byte window per channel
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CFG    = 5'h00;
  localparam logic [4:0] OFF_CNT    = 5'h04;
  localparam logic [4:0] OFF_SRC    = 5'h08;
  localparam logic [4:0] OFF_DST    = 5'h0C;
  localparam logic [4:0] OFF_REM    = 5'h10;
  localparam logic [4:0] OFF_FLAG   = 5'h14;
  localparam logic [4:0] OFF_MASK   = 5'h18;
  localparam logic [4:0] OFF_SWTRIG = 5'h1C;
  localparam logic [CNT_W-1:0] MAX_COUNT = 17'h10000;

  // ----------------------------------------------------------------
  // flag bits, item sizes, priorities
  // ----------------------------------------------------------------
  localparam int FLAG_HALF  = 0;
  localparam int FLAG_DONE  = 1;
  localparam int FLAG_ERR   = 2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] PRIO_LOW   = 2'h0;
  localparam logic [1:0] PRIO_VHIGH = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dmaeState_t;

  // cfg register bits 11..0 in this order from the msb
  typedef struct packed {
    logic [1:0] dstSize;
    logic [1:0] srcSize;
    logic [1:0] prio;
    logic       dstInc;
    logic       srcInc;
    logic       m2m;
    logic       swSel;
    logic       circ;
    logic       en;
  } dmaeCfg_t;

  typedef struct packed {
    dmaeCfg_t         cfg;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rem;
    logic [31:0]      src;
    logic [31:0]      dst;
    logic [31:0]      curSrc;
    logic [31:0]      curDst;
    logic [2:0]       flags;
    logic [2:0]       mask;
    logic             swPend;
  } dmaeChan_t;

endpackage
